// ==== src/csrc_defines.vh ====
// constants of the cpu sideband reset control block
// assumes a 50 MHz core clock and an ahb-lite slave with 32-bit data
`ifndef CSRC_DEFINES_VH
`define CSRC_DEFINES_VH

// register indices as printed; byte address is four times the index
`define CSRC_IDX_FAST_INIT 12'h092
`define CSRC_IDX_NUM_ERR 12'h0f0
`define CSRC_IDX_RST_CTRL 12'h040
`define CSRC_IDX_CONFIG 12'h041
`define CSRC_IDX_STATUS 12'h042

// reset_ctrl_reg fields
`define CSRC_RC_SYS_RST 1
`define CSRC_RC_RST_CPU 2
// fast_init_port fields
`define CSRC_FI_INIT 0
// config register fields
`define CSRC_CFG_FPU_EN 0

// reset values
`define CSRC_FAST_INIT_RST 8'h00
`define CSRC_RST_CTRL_RST 8'h00
`define CSRC_CONFIG_RST 8'h00

// timing
`define CSRC_CLK_PERIOD_NS 20
`define CSRC_CPU_RST_MIN_NS 2000000
`define CSRC_CPU_RST_CYCLES ((`CSRC_CPU_RST_MIN_NS + `CSRC_CLK_PERIOD_NS - 1) / `CSRC_CLK_PERIOD_NS)
`define CSRC_INIT_CYCLES 64

// ahb encodings
`define CSRC_HTRANS_NONSEQ 2'b10
`define CSRC_HRESP_OKAY 1'b0

`endif

// ==== src/csrc_top.v ====
// cpu sideband reset control: hard cpu reset, soft init pulse, numeric error
// handling and the pending-interrupt output, with an ahb-lite register slave
// assumes nrst covers power-good and pci bus reset; pins from outside arrive
// asynchronously and are synchronised here
`timescale 1ns/1ps
`include "csrc_defines.vh"

////////////////////////////////////////////////////////////////////////////////
// Notes on behaviour
// - cpu reset held at power-up, released at least 2 ms after power good.
// - software hard reset holds cpu reset for at least 2 ms.
// - cpu reset released on a rising clock edge.
// - software hard reset also returns internal registers to reset values.
// - processor type selects active level of cpu reset and soft init.
// - numeric error raises internal irq 13, which reaches the cpu interrupt.
// - ignore-error output used only while error reporting is enabled.
// - numeric error register write with error active asserts ignore-error.
// - ignore-error stays asserted until the numeric error input negates.
// - numeric error register write with error inactive leaves ignore-error off.
// - ignore-error released (not driven) in and after reset until asserted.
// - a decoded shutdown special cycle pulses soft init.
// - keyboard reset request or fast init bit 0 write pulses soft init.
// - each soft init pulse lasts 64 clock periods.
// - cpu interrupt output always driven, shows a pending request.
// - cpu interrupt output is asynchronous to the processor side.
module csrc_top #(
	parameter CPU_ACTIVE_LOW = 0,
	parameter CPU_RST_CYCLES = `CSRC_CPU_RST_CYCLES
) (
	input wire core_clk,
	input wire nrst,
	input wire hsel,
	input wire [31:0] haddr,
	input wire [1:0] htrans,
	input wire hwrite,
	input wire [2:0] hsize,
	input wire [31:0] hwdata,
	input wire hready,
	output wire hreadyout,
	output reg [31:0] hrdata,
	output wire hresp,
	input wire powerGoodIn,
	input wire fpuErrorInN,
	input wire kbcResetRequestInN,
	input wire shutdownCycle,
	input wire picIrqIn,
	output wire irq13Out,
	output reg cpuResetOut,
	output reg cpuSoftInitOut,
	output reg cpuIrqOut,
	output wire ignoreFpuErrorOut,
	output reg ignoreFpuErrorOe
);

	localparam RST_CNT_W = 24;
	localparam INIT_CNT_W = 7;
	// counts are worked out as integers and cut to the counter widths on purpose
	localparam integer RST_LAST_I = CPU_RST_CYCLES - 1;
	localparam integer INIT_LAST_I = `CSRC_INIT_CYCLES - 1;
	localparam [RST_CNT_W-1:0] RST_LAST = RST_LAST_I[RST_CNT_W-1:0];
	localparam [INIT_CNT_W-1:0] INIT_LAST = INIT_LAST_I[INIT_CNT_W-1:0];
	// 1 for active-high processor pins, 0 for active-low ones
	localparam [0:0] ACT_LVL = (CPU_ACTIVE_LOW != 0) ? 1'b0 : 1'b1;

	////////////////////////////////////////////////////////////////////////////
	// synchronisers for pins
	reg pgMeta_r;
	reg pgSync_r;
	reg ferrMeta_r;
	reg ferrSync_r;
	reg kbcMeta_r;
	reg kbcSync_r;
	reg kbcPrev_r;

	// power good is a level; no reset, so it keeps tracking the pin during nrst
	always @(posedge core_clk) begin
		pgMeta_r <= powerGoodIn;
		pgSync_r <= pgMeta_r;
	end

	// active-low pins are turned to active-high before the first stage
	always @(posedge core_clk) begin
		ferrMeta_r <= ~fpuErrorInN;
		ferrSync_r <= ferrMeta_r;
	end

	always @(posedge core_clk) begin
		kbcMeta_r <= ~kbcResetRequestInN;
		kbcSync_r <= kbcMeta_r;
	end

	// history reset to the idle (inactive) level, so no false edge follows reset
	always @(posedge core_clk) begin
		if (!nrst) begin
			kbcPrev_r <= 1'b0;
		end else begin
			kbcPrev_r <= kbcSync_r;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// ahb-lite slave, zero wait states
	reg wrPend_r;
	reg [11:0] wrIdx_r;
	reg [7:0] fastInit_r;
	reg [7:0] rstCtrl_r;
	reg [7:0] config_r;
	reg cpuRstAct_r;
	reg initAct_r;
	reg ignoreAct_r;
	reg hardRstReq;
	reg [31:0] rdNxt;
	wire addrPhase;
	wire [11:0] addrIdx;
	wire regRst;
	wire fpuEn;
	wire wrFastInit;
	wire wrRstCtrl;
	wire wrNumErr;
	wire wrConfig;
	wire [7:0] wrByte;

	assign hreadyout = 1'b1;
	assign hresp = `CSRC_HRESP_OKAY;
	assign addrPhase = hsel && hready && (htrans == `CSRC_HTRANS_NONSEQ);
	assign addrIdx = haddr[13:2];
	assign wrByte = hwdata[7:0];
	// a software hard reset wipes the registers along with the processor
	assign regRst = !nrst || hardRstReq;
	assign fpuEn = config_r[`CSRC_CFG_FPU_EN];
	assign wrFastInit = wrPend_r && (wrIdx_r == `CSRC_IDX_FAST_INIT);
	assign wrRstCtrl = wrPend_r && (wrIdx_r == `CSRC_IDX_RST_CTRL);
	assign wrNumErr = wrPend_r && (wrIdx_r == `CSRC_IDX_NUM_ERR);
	assign wrConfig = wrPend_r && (wrIdx_r == `CSRC_IDX_CONFIG);

	always @(posedge core_clk) begin
		if (!nrst) begin
			wrPend_r <= 1'b0;
			wrIdx_r <= 12'h000;
		end else begin
			wrPend_r <= addrPhase && hwrite;
			wrIdx_r <= addrIdx;
		end
	end

	// read data is looked up in the address phase so it stands from a flop
	always @* begin
		rdNxt = 32'h0000_0000;
		if (addrIdx == `CSRC_IDX_FAST_INIT) begin
			rdNxt[7:0] = fastInit_r;
		end else if (addrIdx == `CSRC_IDX_RST_CTRL) begin
			rdNxt[7:0] = rstCtrl_r;
		end else if (addrIdx == `CSRC_IDX_CONFIG) begin
			rdNxt[7:0] = config_r;
		end else if (addrIdx == `CSRC_IDX_STATUS) begin
			rdNxt[5:0] = {cpuIrqOut, ignoreAct_r, ferrSync_r, initAct_r, cpuRstAct_r,
				pgSync_r};
		end
	end

	always @(posedge core_clk) begin
		if (!nrst) begin
			hrdata <= 32'h0000_0000;
		end else if (addrPhase && !hwrite) begin
			hrdata <= rdNxt;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// software registers
	always @(posedge core_clk) begin
		if (regRst) begin
			fastInit_r <= `CSRC_FAST_INIT_RST;
		end else if (wrFastInit) begin
			fastInit_r <= wrByte;
		end
	end

	// the stored value is the reference for the reset-cpu bit's rising edge
	always @(posedge core_clk) begin
		if (regRst) begin
			rstCtrl_r <= `CSRC_RST_CTRL_RST;
		end else if (wrRstCtrl) begin
			rstCtrl_r <= wrByte;
		end
	end

	always @(posedge core_clk) begin
		if (regRst) begin
			config_r <= `CSRC_CONFIG_RST;
		end else if (wrConfig) begin
			config_r <= wrByte;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// hard cpu reset
	reg softInitReq;
	wire rcRise;

	assign rcRise = wrRstCtrl && wrByte[`CSRC_RC_RST_CPU] && !rstCtrl_r[`CSRC_RC_RST_CPU];

	always @* begin
		hardRstReq = nrst && rcRise && wrByte[`CSRC_RC_SYS_RST];
		softInitReq = rcRise && !wrByte[`CSRC_RC_SYS_RST];
	end

	reg [RST_CNT_W-1:0] rstCnt_r;

	// count restarts whenever power good drops, so the hold runs from its last rise
	always @(posedge core_clk) begin
		if (!nrst || !pgSync_r || hardRstReq) begin
			cpuRstAct_r <= 1'b1;
			rstCnt_r <= {RST_CNT_W{1'b0}};
		end else if (cpuRstAct_r) begin
			if (rstCnt_r == RST_LAST) begin
				cpuRstAct_r <= 1'b0;
			end else begin
				rstCnt_r <= rstCnt_r + 1'b1;
			end
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// soft init pulse
	reg [6:0] initCnt_r;
	wire initTrig;

	// a trigger during a running pulse is absorbed by it, not stretched
	assign initTrig = softInitReq || shutdownCycle
		|| (kbcSync_r && !kbcPrev_r)
		|| (wrFastInit && wrByte[`CSRC_FI_INIT]);

	always @(posedge core_clk) begin
		if (!nrst || cpuRstAct_r) begin
			initAct_r <= 1'b0;
			initCnt_r <= 7'h00;
		end else if (initAct_r) begin
			if (initCnt_r == INIT_LAST) begin
				initAct_r <= 1'b0;
			end else begin
				initCnt_r <= initCnt_r + 1'b1;
			end
		end else if (initTrig) begin
			initAct_r <= 1'b1;
			initCnt_r <= 7'h00;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// numeric error and ignore-error
	assign irq13Out = ferrSync_r && fpuEn;

	always @(posedge core_clk) begin
		if (regRst) begin
			ignoreAct_r <= 1'b0;
		end else if (!fpuEn || !ferrSync_r) begin
			ignoreAct_r <= 1'b0;
		end else if (wrNumErr) begin
			ignoreAct_r <= 1'b1;
		end
	end

	// open drain: pin is pulled low only while asserted
	assign ignoreFpuErrorOut = 1'b0;

	////////////////////////////////////////////////////////////////////////////
	// output flops
	// reset output is a flop, so its inactive edge always falls on a clock edge
	always @(posedge core_clk) begin
		if (!nrst) begin
			cpuResetOut <= ACT_LVL;
		end else begin
			cpuResetOut <= cpuRstAct_r ? ACT_LVL : ~ACT_LVL;
		end
	end

	always @(posedge core_clk) begin
		if (!nrst) begin
			cpuSoftInitOut <= ~ACT_LVL;
		end else begin
			cpuSoftInitOut <= initAct_r ? ACT_LVL : ~ACT_LVL;
		end
	end

	// no timing promise to the cpu; it must synchronise this itself
	always @(posedge core_clk) begin
		if (!nrst) begin
			cpuIrqOut <= 1'b0;
		end else begin
			cpuIrqOut <= picIrqIn || irq13Out;
		end
	end

	// enable high pulls the open-drain pin low; low leaves it released
	always @(posedge core_clk) begin
		if (!nrst) begin
			ignoreFpuErrorOe <= 1'b0;
		end else begin
			ignoreFpuErrorOe <= ignoreAct_r;
		end
	end

endmodule // csrc_top

// ==== testbench/csrc_checker.sv ====
// assertions on the ports of the sideband reset control top
// assumes active-high cpu outputs and a shortened hard reset count
`timescale 1ns/1ps
module csrc_checker #(parameter CPU_RST_CYCLES = 20) (
	input wire core_clk,
	input wire nrst,
	input wire hreadyout,
	input wire hresp,
	input wire picIrqIn,
	input wire fpuErrorInN,
	input wire irq13Out,
	input wire cpuResetOut,
	input wire cpuSoftInitOut,
	input wire cpuIrqOut,
	input wire ignoreFpuErrorOut,
	input wire ignoreFpuErrorOe
);
	int rstCnt = 0;
	int initCnt = 0;
	// run lengths of the two reset outputs, cleared when they go idle
	always @(posedge core_clk) rstCnt <= cpuResetOut ? rstCnt + 1 : 0;
	always @(posedge core_clk) initCnt <= cpuSoftInitOut ? initCnt + 1 : 0;
	default clocking cb @(posedge core_clk); endclocking
	default disable iff (!nrst);
	sequence irqReq;
		picIrqIn || irq13Out;
	endsequence
	rst_hold_a: assert property ($fell(cpuResetOut) |-> rstCnt >= CPU_RST_CYCLES)
		else $error("cpu reset released too early");
	init_len_a: assert property ($fell(cpuSoftInitOut) |-> initCnt == 64)
		else $error("init pulse length wrong");
	init_cap_a: assert property (initCnt <= 64)
		else $error("init pulse too long");
	irq_follow_a: assert property (irqReq |=> cpuIrqOut)
		else $error("cpu irq missing");
	irq_quiet_a: assert property (!(picIrqIn || irq13Out) |=> !cpuIrqOut)
		else $error("cpu irq without request");
	irq13_src_a: assert property (irq13Out |-> $past(!fpuErrorInN, 2))
		else $error("irq13 without error");
	ign_err_a: assert property (ignoreFpuErrorOe |-> $past(irq13Out, 2))
		else $error("ignore held without error");
	ign_data_a: assert property (ignoreFpuErrorOut == 1'b0)
		else $error("ignore pin drives high");
	bus_okay_a: assert property (hreadyout && !hresp)
		else $error("bus not ready or error");
endmodule // csrc_checker
bind csrc_top csrc_checker #(.CPU_RST_CYCLES(CPU_RST_CYCLES)) chk_i (.core_clk, .nrst,
	.hreadyout, .hresp, .picIrqIn, .fpuErrorInN, .irq13Out, .cpuResetOut, .cpuSoftInitOut,
	.cpuIrqOut, .ignoreFpuErrorOut, .ignoreFpuErrorOe);

// ==== testbench/csrc_cpu_model.sv ====
// processor side of the sideband pins: raises the numeric error, counts inits
// assumes active-high init and the core clock for its own pin timing
`timescale 1ns/1ps
module csrc_cpu_model (
	input wire core_clk,
	input wire cpuSoftInitOut,
	input wire errReq,
	output logic fpuErrorInN,
	output int initCount
);
	initial initCount = 0;
	initial fpuErrorInN = 1'b1;
	// the error stays until the fault is gone; the ignore pin never clears it
	always @(posedge core_clk) fpuErrorInN <= !errReq;
	always @(posedge cpuSoftInitOut) initCount++;
endmodule // csrc_cpu_model

// ==== testbench/csrc_top_tb.sv ====
// self-checking bench of the sideband reset control block
// assumes one ahb slave, so hready is the slave's own hreadyout
`timescale 1ns/1ps
`include "csrc_defines.vh"
module csrc_top_tb;
	logic core_clk = 0, nrst = 0, hsel = 0, hwrite = 0, powerGoodIn = 0, errReq = 0;
	logic kbcResetRequestInN = 1, shutdownCycle = 0, picIrqIn = 0;
	logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata, q;
	logic [1:0] htrans = 2'h0;
	logic [2:0] hsize = 3'h2;
	wire hreadyout, hresp, irq13Out, cpuResetOut, cpuSoftInitOut, cpuIrqOut, fpuErrorInN;
	wire ignoreFpuErrorOut, ignoreFpuErrorOe;
	int num_errors = 0, n_checks = 0, initCount;
	csrc_top #(.CPU_RST_CYCLES(20)) DUT (.core_clk, .nrst, .hsel, .haddr, .htrans, .hwrite,
		.hsize, .hwdata, .hready(hreadyout), .hreadyout, .hrdata, .hresp, .powerGoodIn,
		.fpuErrorInN, .kbcResetRequestInN, .shutdownCycle, .picIrqIn, .irq13Out, .cpuResetOut,
		.cpuSoftInitOut, .cpuIrqOut, .ignoreFpuErrorOut, .ignoreFpuErrorOe);
	csrc_cpu_model cpu (.core_clk, .cpuSoftInitOut, .errReq, .fpuErrorInN, .initCount);
	initial forever #10 core_clk = ~core_clk;
	////////////////////////////////////////////////////////////////
	task chk(input logic [31:0] got, input logic [31:0] exp);
		n_checks++;
		if (got !== exp) begin
			num_errors++;
			$display("BAD %0t got %h want %h", $time, got, exp);
		end
	endtask
	task bus(input logic w, input logic [11:0] i, input logic [31:0] d);
		@(posedge core_clk);
		hsel <= 1'b1;
		htrans <= `CSRC_HTRANS_NONSEQ;
		hwrite <= w;
		haddr <= {18'h0, i, 2'h0};
		do @(posedge core_clk); while (hreadyout !== 1'b1);
		htrans <= 2'h0;
		hwdata <= d;
		do @(posedge core_clk); while (hreadyout !== 1'b1);
		q = hrdata;
	endtask
	// counts negedges while a reset output stays high
	task runLen(input logic init, output int n);
		n = 0;
		repeat (8) if ((init ? cpuSoftInitOut : cpuResetOut) !== 1'b1) @(negedge core_clk);
		while ((init ? cpuSoftInitOut : cpuResetOut) === 1'b1 && n < 99) begin
			@(negedge core_clk);
			n++;
		end
	endtask
	task t_power;
		int n;
		@(negedge core_clk);
		chk({cpuResetOut, cpuSoftInitOut, cpuIrqOut, ignoreFpuErrorOe}, 32'h8);
		repeat (2) @(posedge core_clk);
		nrst <= 1'b1;
		powerGoodIn <= 1'b1;
		runLen(1'b0, n);
		chk(n >= 21, 32'h1);
	endtask
	task t_hard;
		int n;
		bus(1'b1, `CSRC_IDX_CONFIG, 32'h1);
		bus(1'b1, `CSRC_IDX_FAST_INIT, 32'ha4);
		bus(1'b1, `CSRC_IDX_RST_CTRL, 32'h6);
		repeat (3) @(negedge core_clk);
		runLen(1'b0, n);
		chk(n >= 16, 32'h1);
		bus(1'b0, `CSRC_IDX_CONFIG, 32'h0);
		chk(q, 32'h0);
		bus(1'b0, `CSRC_IDX_FAST_INIT, 32'h0);
		chk(q, 32'h0);
	endtask
	task t_init;
		int n;
		for (int k = 0; k < 4; k++) begin
			case (k)
				0: bus(1'b1, `CSRC_IDX_RST_CTRL, 32'h4);
				1: bus(1'b1, `CSRC_IDX_FAST_INIT, 32'h1);
				2: begin
					@(posedge core_clk);
					kbcResetRequestInN <= 1'b0;
					@(posedge core_clk);
					kbcResetRequestInN <= 1'b1;
				end
				default: begin
					@(posedge core_clk);
					shutdownCycle <= 1'b1;
					@(posedge core_clk);
					shutdownCycle <= 1'b0;
				end
			endcase
			runLen(1'b1, n);
			chk(n, 32'h40);
		end
		chk(initCount, 32'h4);
		bus(1'b1, `CSRC_IDX_RST_CTRL, 32'h0);
	endtask
	task t_err;
		bus(1'b1, `CSRC_IDX_NUM_ERR, 32'h0);
		repeat (3) @(negedge core_clk);
		chk(ignoreFpuErrorOe, 32'h0);
		@(posedge core_clk);
		errReq <= 1'b1;
		repeat (4) @(posedge core_clk);
		bus(1'b1, `CSRC_IDX_NUM_ERR, 32'h0);
		repeat (3) @(negedge core_clk);
		chk({irq13Out, ignoreFpuErrorOe}, 32'h0);
		bus(1'b1, `CSRC_IDX_CONFIG, 32'h1);
		bus(1'b1, `CSRC_IDX_NUM_ERR, 32'h0);
		repeat (9) @(negedge core_clk);
		chk({irq13Out, cpuIrqOut, ignoreFpuErrorOe}, 32'h7);
		bus(1'b0, `CSRC_IDX_STATUS, 32'h0);
		chk(q, 32'h39);
		@(posedge core_clk);
		errReq <= 1'b0;
		repeat (6) @(negedge core_clk);
		chk({irq13Out, cpuIrqOut, ignoreFpuErrorOe}, 32'h0);
	endtask
	task t_irq;
		@(posedge core_clk);
		picIrqIn <= 1'b1;
		repeat (2) @(negedge core_clk);
		chk(cpuIrqOut, 32'h1);
		@(posedge core_clk);
		picIrqIn <= 1'b0;
		bus(1'b1, 12'h3ff, 32'h5a);
		bus(1'b0, 12'h3ff, 32'h0);
		chk(q, 32'h0);
		chk(cpuIrqOut, 32'h0);
	endtask
	task summarize;
		$display("checks %0d errors %0d", n_checks, num_errors);
		if (num_errors == 0 && n_checks > 0) $display("All tests passed");
		else $display("Some tests failed");
		$finish;
	endtask
	initial begin
		t_power;
		t_hard;
		t_init;
		t_err;
		t_irq;
		summarize;
	end
	initial begin
		#100000;
		num_errors++;
		summarize;
	end
endmodule // csrc_top_tb
